/* File: common/exec_pkg.sv */
// constants for the table-write / xor / test-skip execution block
// assumes a 16-bit instruction word and four phases per instruction cycle
package exec_pkg;
	localparam int PTR_W = 21;
	localparam int HOLD_N = 8;
	localparam int HOLD_SEL_W = 3;
	localparam logic [15:0] TABLE_WR_MASK = 16'hFFFC;
	localparam logic [15:0] TABLE_WR_CODE = 16'h000C;
	localparam logic [15:0] XORL_MASK = 16'hFF00;
	localparam logic [15:0] XORL_CODE = 16'h0A00;
	localparam logic [15:0] XORF_MASK = 16'hFC00;
	localparam logic [15:0] XORF_CODE = 16'h1800;
	localparam logic [15:0] TSTZ_MASK = 16'hFE00;
	localparam logic [15:0] TSTZ_CODE = 16'h6600;
	localparam logic [1:0] MODE_KEEP = 2'h0;
	localparam logic [1:0] MODE_POST_INC = 2'h1;
	localparam logic [1:0] MODE_POST_DEC = 2'h2;
	localparam logic [1:0] MODE_PRE_INC = 2'h3;
	localparam int BIT_ACCESS = 8;
	localparam int BIT_DEST = 9;
	localparam logic [3:0] ACCESS_BANK = 4'h0;
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q4 = 2'h3;
	localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : exec_pkg

/* File: verilog/phase_gen.sv */
// four-phase generator for the instruction cycle
// assumes one ref_clk edge per phase
`timescale 1ns/1ns
module phase_gen (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	output logic [1:0] phase,
	output logic cycle_end
);
	logic [1:0] phase_r;
	logic [1:0] phase_nxt;

	always_comb begin
		phase_nxt = phase_r + 2'h1;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= exec_pkg::PH_Q1;
		end else if (clk_en) begin
			phase_r <= phase_nxt;
		end
	end

	assign phase = phase_r;
	assign cycle_end = clk_en && (phase_r == exec_pkg::PH_Q4);
endmodule : phase_gen

/* File: verilog/table_write_xor_skip_exec.sv */
// execution logic for table write, xor literal/register and test-skip-zero
// assumes the fetch unit holds instr stable over a whole cycle and that the
// register file returns file_rd_data combinationally for file_addr
//
// Overview of operation
// - table write low two bits pick keep, post-inc, post-dec or pre-inc
// - table write copies latch into holding register picked by pointer[2:0]
// - table pointer is 21 bits, byte addressed, 2-Mbyte range
// - pointer bit 0 low selects low byte, high selects high byte
// - test skip reads register; zero discards fetched next instruction
// - test skip: one cycle, two if skipping, three over two-word instruction
// - access bit 0 forces access bank; 1 uses bank select register
// - xor literal puts working register xor literal into working register
// - xor register writes to working register if d=0, else to file
// - xors set only negative and zero; others leave flags alone
`timescale 1ns/1ns
module table_write_xor_skip_exec #(
	parameter int PTR_W = exec_pkg::PTR_W,
	parameter int HOLD_N = exec_pkg::HOLD_N
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [15:0] instr,
	input wire logic next_two_word,
	input wire logic [7:0] table_latch,
	input wire logic [3:0] bank_select_reg,
	input wire logic [7:0] file_rd_data,
	output logic [11:0] file_addr,
	output logic [7:0] file_wr_data,
	output logic file_wr_en,
	output logic [7:0] w_reg,
	output logic neg_flag,
	output logic zero_flag,
	output logic [PTR_W-1:0] table_pointer,
	output logic [7:0] hold_data [HOLD_N],
	output logic [1:0] phase,
	output logic flush_next,
	output logic busy,
	output logic byte_high_sel
);
	typedef enum logic [3:0] {
		ST_EXEC = 4'h1,
		ST_TABLE_WR2 = 4'h2,
		ST_SKIP1 = 4'h4,
		ST_SKIP2 = 4'h8
	} state_t;

	function automatic logic match(input logic [15:0] v,
		input logic [15:0] m, input logic [15:0] c);
		match = (v & m) == c;
	endfunction : match

	function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p,
		input logic up);
		step = up ? PTR_W'(p + 1'b1) : PTR_W'(p - 1'b1);
	endfunction : step

	logic cycle_end;
	state_t state_r, state_nxt;
	logic [PTR_W-1:0] ptr_r, ptr_nxt;
	logic [7:0] w_r, w_nxt;
	logic neg_r, neg_nxt, zero_r, zero_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [7:0] latch_cap_r, latch_cap_nxt;
	logic [7:0] hold_r [HOLD_N];
	logic hold_we;
	logic [exec_pkg::HOLD_SEL_W-1:0] hold_sel;
	logic is_table_wr, is_xorl, is_xorf, is_tstz;
	logic [7:0] xor_res;

	phase_gen u_phase (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.phase(phase),
		.cycle_end(cycle_end)
	);

	////////////////////////////////////////////////////////////////////////
	// decode

	always_comb begin
		is_table_wr = match(instr, exec_pkg::TABLE_WR_MASK,
			exec_pkg::TABLE_WR_CODE);
		is_xorl = match(instr, exec_pkg::XORL_MASK, exec_pkg::XORL_CODE);
		is_xorf = match(instr, exec_pkg::XORF_MASK, exec_pkg::XORF_CODE);
		is_tstz = match(instr, exec_pkg::TSTZ_MASK, exec_pkg::TSTZ_CODE);
		// a=0 ignores the bank register
		file_addr = {instr[exec_pkg::BIT_ACCESS] ? bank_select_reg
			: exec_pkg::ACCESS_BANK, instr[7:0]};
		xor_res = is_xorl ? (w_r ^ instr[7:0])
			: (w_r ^ file_rd_data);
		file_wr_data = xor_res;
		file_wr_en = clk_en && state_r == ST_EXEC && is_xorf
			&& instr[exec_pkg::BIT_DEST] && phase == exec_pkg::PH_Q4;
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer, pointer, working register and flags

	always_comb begin
		state_nxt = state_r;
		ptr_nxt = ptr_r;
		w_nxt = w_r;
		neg_nxt = neg_r;
		zero_nxt = zero_r;
		mode_nxt = mode_r;
		latch_cap_nxt = latch_cap_r;
		hold_we = 1'b0;
		case (state_r)
		ST_EXEC: begin
			if (cycle_end) begin
				if (is_table_wr) begin
					mode_nxt = instr[1:0];
					state_nxt = ST_TABLE_WR2;
					if (instr[1:0] == exec_pkg::MODE_PRE_INC) begin
						ptr_nxt = step(ptr_r, 1'b1);
					end
				end else if (is_tstz && file_rd_data == 8'h00) begin
					state_nxt = ST_SKIP1;
				end else if (is_xorl ||
					(is_xorf && !instr[exec_pkg::BIT_DEST])) begin
					w_nxt = xor_res;
				end
				if (is_xorl || is_xorf) begin
					neg_nxt = xor_res[7];
					zero_nxt = xor_res == 8'h00;
				end
			end
		end
		ST_TABLE_WR2: begin
			if (clk_en && phase == exec_pkg::PH_Q2) begin
				latch_cap_nxt = table_latch;
			end
			if (cycle_end) begin
				hold_we = 1'b1;
				state_nxt = ST_EXEC;
				case (mode_r)
				exec_pkg::MODE_POST_INC: ptr_nxt = step(ptr_r, 1'b1);
				exec_pkg::MODE_POST_DEC: ptr_nxt = step(ptr_r, 1'b0);
				default: ptr_nxt = ptr_r;
				endcase
			end
		end
		ST_SKIP1: begin
			// second word of a two-word instruction is also swallowed
			if (cycle_end) begin
				state_nxt = next_two_word ? ST_SKIP2 : ST_EXEC;
			end
		end
		ST_SKIP2: begin
			if (cycle_end) begin
				state_nxt = ST_EXEC;
			end
		end
		default: begin
			state_nxt = ST_EXEC;
		end
		endcase
	end

	assign hold_sel = ptr_r[exec_pkg::HOLD_SEL_W-1:0];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_EXEC;
			ptr_r <= exec_pkg::PTR_RESET;
			w_r <= exec_pkg::W_RESET;
			neg_r <= 1'b0;
			zero_r <= 1'b0;
			mode_r <= exec_pkg::MODE_KEEP;
			latch_cap_r <= exec_pkg::BYTE_RESET;
		end else if (clk_en) begin
			state_r <= state_nxt;
			ptr_r <= ptr_nxt;
			w_r <= w_nxt;
			neg_r <= neg_nxt;
			zero_r <= zero_nxt;
			mode_r <= mode_nxt;
			latch_cap_r <= latch_cap_nxt;
		end
	end

	// capture uses the Q2 copy so a late latch change cannot leak in
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < HOLD_N; i++) begin
				hold_r[i] <= exec_pkg::BYTE_RESET;
			end
		end else if (clk_en && hold_we) begin
			hold_r[hold_sel] <= latch_cap_r;
		end
	end

	assign table_pointer = ptr_r;
	assign byte_high_sel = ptr_r[0];
	assign w_reg = w_r;
	assign neg_flag = neg_r;
	assign zero_flag = zero_r;
	assign hold_data = hold_r;
	assign flush_next = state_r == ST_SKIP1 || state_r == ST_SKIP2;
	assign busy = state_r != ST_EXEC;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_table_wr_start;
		state_r == ST_EXEC && is_table_wr && cycle_end;
	endsequence

	sequence s_table_wr_end;
		state_r == ST_TABLE_WR2 && cycle_end;
	endsequence

	sequence s_skip1_end;
		state_r == ST_SKIP1 && cycle_end;
	endsequence

	sequence s_xorf_exec;
		state_r == ST_EXEC && is_xorf && cycle_end;
	endsequence

	a_table_wr_two: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_table_wr_start |=> state_r == ST_TABLE_WR2)
		else $error("table write did not enter second cycle");

	a_pre_inc_ptr: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_table_wr_start ##0 (instr[1:0] == exec_pkg::MODE_PRE_INC)
		|=> ptr_r == PTR_W'($past(ptr_r) + 1'b1))
		else $error("pre-increment did not advance pointer");

	a_post_inc_ptr: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_table_wr_end ##0 (mode_r == exec_pkg::MODE_POST_INC)
		|=> ptr_r == PTR_W'($past(ptr_r) + 1'b1))
		else $error("post-increment did not advance pointer");

	a_post_dec_ptr: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_table_wr_end ##0 (mode_r == exec_pkg::MODE_POST_DEC)
		|=> ptr_r == PTR_W'($past(ptr_r) - 1'b1))
		else $error("post-decrement wrong");

	a_keep_ptr: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_table_wr_end ##0 (mode_r == exec_pkg::MODE_KEEP)
		|=> $stable(ptr_r))
		else $error("keep mode moved the pointer");

	a_latch_capture: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		state_r == ST_TABLE_WR2 && clk_en && phase == exec_pkg::PH_Q2
		|=> latch_cap_r == $past(table_latch))
		else $error("latch byte not captured in second phase");

	a_hold_write: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_table_wr_end
		|=> hold_r[$past(hold_sel)] == $past(latch_cap_r))
		else $error("holding register not written");

	a_skip_zero: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		state_r == ST_EXEC && is_tstz && cycle_end && file_rd_data == 8'h00
		|=> flush_next [*4])
		else $error("zero test did not skip");

	a_no_skip: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		state_r == ST_EXEC && is_tstz && cycle_end && file_rd_data != 8'h00
		|=> !flush_next)
		else $error("nonzero test skipped");

	a_skip_two_word: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_skip1_end ##0 next_two_word |=> state_r == ST_SKIP2)
		else $error("two-word skip did not add a third cycle");

	a_skip_one_word: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_skip1_end ##0 !next_two_word |=> state_r == ST_EXEC)
		else $error("one-word skip lasted too long");

	a_xorl_result: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		state_r == ST_EXEC && is_xorl && cycle_end
		|=> w_r == ($past(w_r) ^ $past(instr[7:0]))
		&& zero_flag == (w_r == 8'h00) && neg_flag == w_r[7])
		else $error("xor literal result wrong");

	a_xorf_to_w: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_xorf_exec ##0 !instr[exec_pkg::BIT_DEST]
		|=> w_r == ($past(w_r) ^ $past(file_rd_data)))
		else $error("xor register result not in working register");

	a_xorf_to_file: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		s_xorf_exec ##0 instr[exec_pkg::BIT_DEST]
		|-> file_wr_en ##1 $stable(w_r))
		else $error("xor register result not sent to the file");

	a_access_bank: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		!instr[exec_pkg::BIT_ACCESS]
		|-> file_addr[11:8] == exec_pkg::ACCESS_BANK)
		else $error("access bit low did not force the access bank");

	a_flags_kept: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		state_r == ST_EXEC && (is_tstz || is_table_wr) && cycle_end
		|=> $stable(neg_r) && $stable(zero_r))
		else $error("flags changed by non-xor instruction");

	a_enable_freeze: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		!clk_en
		|=> $stable(phase) && $stable(state_r) && $stable(ptr_r)
		&& $stable(w_r))
		else $error("state moved while clock enable was low");
endmodule : table_write_xor_skip_exec

/* File: sim/tb_top.sv */
// self-checking bench for the table write / xor / test-skip execution block
// assumes a zero-wait register file model answering file_addr at once
`timescale 1ns/1ns
module tb_top;
	localparam logic [7:0] LAT [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	localparam logic [20:0] PTR [4] = '{21'h0, 21'h1FFFFF, 21'h0, 21'h1};
	localparam int IDX [4] = '{0, 0, 7, 1};
	// keep, post-dec, post-inc, pre-inc: walks the pointer through its wrap
	localparam logic [1:0] MD [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [15:0] instr = 16'h0000;
	logic next_two_word = 1'b0;
	logic [7:0] table_latch = 8'h00;
	logic [3:0] bank_select_reg = 4'h0;
	wire logic [7:0] file_rd_data;
	logic [11:0] file_addr;
	logic [7:0] file_wr_data;
	logic file_wr_en;
	logic [7:0] w_reg;
	logic neg_flag;
	logic zero_flag;
	logic [20:0] table_pointer;
	logic [7:0] hold_data [8];
	logic [1:0] phase;
	logic flush_next;
	logic busy;
	logic byte_high_sel;
	logic [7:0] fmem [4096];
	int num_errors = 0;
	int tests_run = 0;
	always #10 ref_clk = ~ref_clk;
	assign file_rd_data = fmem[file_addr];
	always @(posedge ref_clk) begin
		if (file_wr_en === 1'b1) fmem[file_addr] <= file_wr_data;
	end
	table_write_xor_skip_exec #(.PTR_W(21), .HOLD_N(8))
		table_write_xor_skip_exec_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.clk_en(clk_en), .instr(instr), .next_two_word(next_two_word),
		.table_latch(table_latch), .bank_select_reg(bank_select_reg),
		.file_rd_data(file_rd_data), .file_addr(file_addr),
		.file_wr_data(file_wr_data), .file_wr_en(file_wr_en),
		.w_reg(w_reg), .neg_flag(neg_flag), .zero_flag(zero_flag),
		.table_pointer(table_pointer), .hold_data(hold_data),
		.phase(phase), .flush_next(flush_next), .busy(busy),
		.byte_high_sel(byte_high_sel));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [20:0] got, input logic [20:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wf(input logic [7:0] w, input logic [1:0] nz);
		check({11'h000, w_reg, neg_flag, zero_flag}, {11'h000, w, nz});
	endtask : wf
	// stops on an edge that ends Q4, where an instruction is taken
	task automatic sync;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (phase !== 2'h3 && n < 8);
		check({19'h0, phase}, 21'h3);
	endtask : sync
	task automatic issue(input logic [15:0] op);
		sync;
		instr <= op;
		sync;
		instr <= 16'h0000;
		#1;
	endtask : issue
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		num_errors++;
		final_report;
	end
	initial begin
		for (int i = 0; i < 4096; i++) fmem[i] = i[7:0];
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		issue(16'h0AB5);
		wf(8'hB5, 2'b10);
		issue(16'h0AAF);
		wf(8'h1A, 2'b00);
		issue(16'h0A1A);
		wf(8'h00, 2'b01);
		$display("xor literal test done");
		bank_select_reg <= 4'h5;
		fmem[12'h020] = 8'hAF;
		fmem[12'h520] = 8'h0F;
		issue(16'h1820);
		wf(8'hAF, 2'b10);
		issue(16'h1920);
		wf(8'hA0, 2'b10);
		issue(16'h1B20);
		wf(8'hA0, 2'b10);
		check({13'h0, fmem[12'h520]}, 21'hAF);
		issue(16'h1A20);
		wf(8'hA0, 2'b00);
		check({13'h0, fmem[12'h020]}, 21'h0F);
		$display("xor register test done");
		fmem[12'h030] = 8'h01;
		fmem[12'h530] = 8'h00;
		issue(16'h6630);
		check({20'h0, flush_next}, 21'h0);
		fmem[12'h030] = 8'h00;
		issue(16'h6630);
		check({20'h0, flush_next}, 21'h1);
		sync;
		#1;
		check({20'h0, flush_next}, 21'h0);
		next_two_word <= 1'b1;
		fmem[12'h030] = 8'h01;
		issue(16'h6730);
		check({20'h0, flush_next}, 21'h1);
		sync;
		#1;
		check({20'h0, flush_next}, 21'h1);
		sync;
		#1;
		check({20'h0, flush_next}, 21'h0);
		next_two_word <= 1'b0;
		wf(8'hA0, 2'b00);
		$display("test skip test done");
		for (int k = 0; k < 4; k++) begin
			sync;
			instr <= {14'h0003, MD[k]};
			table_latch <= ~LAT[k];
			sync;
			// an xor offered in the busy cycle must be ignored
			instr <= 16'h0AFF;
			table_latch <= LAT[k];
			#1;
			check({20'h0, busy}, 21'h1);
			repeat (2) @(posedge ref_clk);
			table_latch <= ~LAT[k];
			sync;
			instr <= 16'h0000;
			#1;
			check({13'h0, hold_data[IDX[k]]}, {13'h0, LAT[k]});
			check(table_pointer, PTR[k]);
			check({20'h0, byte_high_sel}, {20'h0, PTR[k][0]});
			wf(8'hA0, 2'b00);
			check({20'h0, busy}, 21'h0);
		end
		$display("table write test done");
		// an xor held while the enable is low must wait for the enable
		sync;
		instr <= 16'h0A0F;
		clk_en <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		check({19'h0, phase}, 21'h0);
		wf(8'hA0, 2'b00);
		clk_en <= 1'b1;
		sync;
		instr <= 16'h0000;
		#1;
		wf(8'hAF, 2'b10);
		$display("clock enable test done");
		final_report;
	end
endmodule : tb_top
